// File: design/sca_pkg.sv
// Constants, register map and channel grouping table of the stream combiner and AGC
package sca_pkg;

  // ------------------------------------------------------------
  // Datapath widths
  // ------------------------------------------------------------
  localparam int NCH    = 6;
  localparam int IN_W   = 22;
  localparam int OUT_W  = 16;
  localparam int INT_W  = 32;
  localparam int GAIN_W = 12;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_OUT_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_AGC_CTRL0  = 8'h10;
  localparam logic [7:0] ADDR_AGC_GAIN0  = 8'h40;
  localparam logic [7:0] ADDR_STRIDE     = 8'h04;

  // Output control fields
  localparam int STRM_LSB = 0;
  localparam int CPLX_LSB = 4;
  localparam logic [3:0] STRM_RST = 4'hf;
  localparam logic [2:0] CPLX_RST = 3'h0;

  // AGC control fields
  localparam int AGC_BYP_BIT  = 0;
  localparam int AGC_MODE_BIT = 1;
  localparam int AGC_WL_LSB   = 2;
  localparam int AGC_DES_LSB  = 8;
  localparam int AGC_K_LSB    = 16;
  localparam logic [31:0] AGC_CTRL_RST = 32'h0010_2001;
  localparam logic [31:0] AGC_CTRL_MSK = 32'h00ff_ff1f;

  // Gain loop
  localparam int K_SHIFT = 4;
  localparam logic [GAIN_W-1:0] GAIN_RST = 12'h000;
  localparam int PWR_LSB = 4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Complex control special values
  localparam logic [2:0] CPLX_NONE  = 3'b000;
  localparam logic [2:0] CPLX_UNDEF = 3'b100;

  // ------------------------------------------------------------
  // Grouping: leader stream of each channel, three bits per channel
  // ------------------------------------------------------------
  function automatic logic [17:0] sca_leaders(input logic [3:0] sc);
    case (sc)
      4'h0:    sca_leaders = {3'd5, 3'd4, 3'd3, 3'd2, 3'd0, 3'd0};
      4'h1:    sca_leaders = {3'd5, 3'd4, 3'd3, 3'd0, 3'd0, 3'd0};
      4'h2:    sca_leaders = {3'd5, 3'd4, 3'd0, 3'd0, 3'd0, 3'd0};
      4'h3:    sca_leaders = {3'd5, 3'd0, 3'd0, 3'd0, 3'd0, 3'd0};
      4'h4:    sca_leaders = {3'd0, 3'd0, 3'd0, 3'd0, 3'd0, 3'd0};
      4'h5:    sca_leaders = {3'd3, 3'd3, 3'd3, 3'd0, 3'd0, 3'd0};
      4'h6:    sca_leaders = {3'd4, 3'd4, 3'd2, 3'd2, 3'd0, 3'd0};
      4'h7:    sca_leaders = {3'd5, 3'd4, 3'd2, 3'd2, 3'd0, 3'd0};
      4'h8:    sca_leaders = {3'd5, 3'd3, 3'd3, 3'd0, 3'd0, 3'd0};
      4'h9:    sca_leaders = {3'd4, 3'd4, 3'd0, 3'd0, 3'd0, 3'd0};
      default: sca_leaders = {3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0};
    endcase
  endfunction

  // Output word length code to bit count
  function automatic logic [4:0] sca_wlen(input logic [2:0] code);
    case (code)
      3'h5:    sca_wlen = 5'd10;
      3'h6:    sca_wlen = 5'd12;
      3'h7:    sca_wlen = 5'd16;
      default: sca_wlen = 5'(code) + 5'd4;
    endcase
  endfunction

endpackage

// File: design/sca_top.sv
// Output stream router, pair combiner and six AGC loops with an AXI4-Lite register slave
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Complex pair: I = I*real - Q*imag, Q = I*imag + Q*real.
// - Three-bit complex word picks merged pairs and complex or biphase kind.
// - Complex word 000 merges nothing; stream word alone decides grouping.
// - Values 001/010/011 complete complex filters on first one, two, three pairs.
// - Values 101/110/111 biphase-sum the first one, two, three pairs.
// - Biphase: I is even plus odd I, Q is even plus odd Q.
// - Stream values 0..4 interleave channel 0 with the next one to five.
// - Stream values 5..9 form listed groups; others keep six independent streams.
// - Merged result goes to the lower AGC; the upper stream goes idle.
// - Six independent AGC loops, 96 dB range, between router and outputs.
// - Each AGC compresses 22 bits to 4..8, 10, 12 or 16 bits.
// - Bypass passes data ungained, still truncated to 16 bits.
// - Output truncates bits below range and clips values above range.
// - Loop works in log domain: power, error, loop filter, gain multiply.
// - Mode bit picks signal-level or clipping-level target for gain adjustment.
// - Signal-level mode measures only the data before clipping.
// - Clipping-level mode measures pre-clip minus post-clip data.
// - Interleaved stream holds one sample per channel; a sample not sent before the next one arrives is lost.
// - Four-bit stream field sits in the output control register with complex word.
// - Mode bit zero is signal level, power computed as I squared plus Q squared.
module sca_top
  import sca_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  input  wire logic [NCH*IN_W-1:0]  i_ch_i,
  input  wire logic [NCH*IN_W-1:0]  i_ch_q,
  input  wire logic [NCH-1:0]       i_ch_valid,
  output logic      [NCH*OUT_W-1:0] o_str_i,
  output logic      [NCH*OUT_W-1:0] o_str_q,
  output logic      [NCH-1:0]       o_str_valid,
  input  wire logic [ADDR_W-1:0]    i_s_axi_awaddr,
  input  wire logic                 i_s_axi_awvalid,
  output logic                      o_s_axi_awready,
  input  wire logic [31:0]          i_s_axi_wdata,
  input  wire logic [3:0]           i_s_axi_wstrb,
  input  wire logic                 i_s_axi_wvalid,
  output logic                      o_s_axi_wready,
  output logic [1:0]                o_s_axi_bresp,
  output logic                      o_s_axi_bvalid,
  input  wire logic                 i_s_axi_bready,
  input  wire logic [ADDR_W-1:0]    i_s_axi_araddr,
  input  wire logic                 i_s_axi_arvalid,
  output logic                      o_s_axi_arready,
  output logic [31:0]               o_s_axi_rdata,
  output logic [1:0]                o_s_axi_rresp,
  output logic                      o_s_axi_rvalid,
  input  wire logic                 i_s_axi_rready
);

  // ------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------
  logic [3:0]        strm_ctl;
  logic [2:0]        cplx_ctl;
  logic [31:0]       agc_ctl [NCH];
  logic [GAIN_W-1:0] gain    [NCH];
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              aw_got;
  logic              w_got;
  logic              do_wr;
  logic [31:0]       wr_word;
  logic [31:0]       rd_word;
  logic              rd_ok;

  assign do_wr = aw_got && w_got && !o_s_axi_bvalid;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_word[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : 8'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      aw_got          <= 1'b0;
      w_got           <= 1'b0;
      aw_addr         <= '0;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_got  <= 1'b1;
        aw_addr <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_got  <= 1'b1;
        w_data <= i_s_axi_wdata;
        w_strb <= i_s_axi_wstrb;
      end
      o_s_axi_awready <= !aw_got && !(i_s_axi_awvalid && o_s_axi_awready) && !do_wr;
      o_s_axi_wready  <= !w_got && !(i_s_axi_wvalid && o_s_axi_wready) && !do_wr;
      if (do_wr) begin
        aw_got         <= 1'b0;
        w_got          <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= RESP_SLVERR;
        if (aw_addr == ADDR_OUT_CTRL) begin
          o_s_axi_bresp <= RESP_OKAY;
        end
        for (int k = 0; k < NCH; k++) begin
          if (aw_addr == ADDR_W'(ADDR_AGC_CTRL0 + ADDR_STRIDE * k)) begin
            o_s_axi_bresp <= RESP_OKAY;
          end
        end
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers; byte strobes merge into the old value
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strm_ctl <= STRM_RST;
      cplx_ctl <= CPLX_RST;
      for (int k = 0; k < NCH; k++) begin
        agc_ctl[k] <= AGC_CTRL_RST;
      end
    end else if (do_wr) begin
      if (aw_addr == ADDR_OUT_CTRL && w_strb[0]) begin
        strm_ctl <= w_data[STRM_LSB +: 4];
        cplx_ctl <= w_data[CPLX_LSB +: 3];
      end
      for (int k = 0; k < NCH; k++) begin
        if (aw_addr == ADDR_W'(ADDR_AGC_CTRL0 + ADDR_STRIDE * k)) begin
          for (int b = 0; b < 4; b++) begin
            if (w_strb[b]) begin
              agc_ctl[k][b*8 +: 8] <= wr_word[b*8 +: 8] & AGC_CTRL_MSK[b*8 +: 8];
            end
          end
        end
      end
    end
  end

  // Read decode; gain registers show each loop's live gain
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b0;
    if (i_s_axi_araddr == ADDR_OUT_CTRL) begin
      rd_word = {25'h0, cplx_ctl, strm_ctl};
      rd_ok   = 1'b1;
    end
    for (int k = 0; k < NCH; k++) begin
      if (i_s_axi_araddr == ADDR_W'(ADDR_AGC_CTRL0 + ADDR_STRIDE * k)) begin
        rd_word = agc_ctl[k];
        rd_ok   = 1'b1;
      end else if (i_s_axi_araddr == ADDR_W'(ADDR_AGC_GAIN0 + ADDR_STRIDE * k)) begin
        rd_word = {20'h0, gain[k]};
        rd_ok   = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= RESP_OKAY;
    end else begin
      o_s_axi_arready <= !o_s_axi_rvalid && !(i_s_axi_arvalid && o_s_axi_arready);
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata  <= rd_word;
        o_s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Interleaving router
  // ------------------------------------------------------------
  // One held sample per channel; a channel that delivers again before its
  // held sample is sent loses the older one, so groups must be phase staggered.
  logic [17:0]          leads;
  logic [NCH-1:0]       pend;
  logic [IN_W-1:0]      pi [NCH];
  logic [IN_W-1:0]      pq [NCH];
  logic [NCH-1:0]       hit;
  logic [2:0]           sel [NCH];
  logic [NCH-1:0]       take;
  logic [NCH-1:0]       rv;
  logic [IN_W-1:0]      ri [NCH];
  logic [IN_W-1:0]      rq [NCH];

  assign leads = sca_leaders(strm_ctl);

  always_comb begin
    for (int s = 0; s < NCH; s++) begin
      hit[s] = 1'b0;
      sel[s] = 3'd0;
      for (int c = NCH - 1; c >= 0; c--) begin
        if (pend[c] && leads[c*3 +: 3] == 3'(s)) begin
          hit[s] = 1'b1;
          sel[s] = 3'(c);
        end
      end
    end
    for (int c = 0; c < NCH; c++) begin
      take[c] = hit[leads[c*3 +: 3]] && sel[leads[c*3 +: 3]] == 3'(c);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend <= '0;
      rv   <= '0;
      for (int c = 0; c < NCH; c++) begin
        pi[c] <= '0;
        pq[c] <= '0;
        ri[c] <= '0;
        rq[c] <= '0;
      end
    end else begin
      // held samples leave one per cycle per stream; a new delivery overwrites one not yet sent
      pend <= i_ch_valid | (pend & ~take);
      for (int c = 0; c < NCH; c++) begin
        if (i_ch_valid[c]) begin
          pi[c] <= i_ch_i[c*IN_W +: IN_W];
          pq[c] <= i_ch_q[c*IN_W +: IN_W];
        end
      end
      rv <= hit;
      for (int s = 0; s < NCH; s++) begin
        ri[s] <= pi[sel[s]];
        rq[s] <= pq[sel[s]];
      end
    end
  end

  // ------------------------------------------------------------
  // Pair combiner and AGC loops
  // ------------------------------------------------------------
  logic [1:0] npairs;
  logic       biphase;

  assign npairs  = (cplx_ctl == CPLX_NONE || cplx_ctl == CPLX_UNDEF) ? 2'd0 : cplx_ctl[1:0];
  assign biphase = cplx_ctl[2];

  genvar p;
  generate
    for (p = 0; p < NCH / 2; p++) begin : g_pair
      logic                   act;
      logic                   hl;
      logic                   hh;
      logic signed [IN_W-1:0] li;
      logic signed [IN_W-1:0] lq;
      logic signed [IN_W-1:0] ui;
      logic signed [IN_W-1:0] uq;
      logic signed [IN_W-1:0] e_i;
      logic signed [IN_W-1:0] e_q;
      logic signed [IN_W-1:0] o_i;
      logic signed [IN_W-1:0] o_q;
      logic signed [IN_W:0]   si;
      logic signed [IN_W:0]   sq;
      logic                   fire;
      logic                   cv   [2];
      logic signed [IN_W-1:0] fi   [2];
      logic signed [IN_W-1:0] fq   [2];

      assign act  = 2'(p) < npairs;
      assign e_i  = rv[2*p] ? signed'(ri[2*p]) : li;
      assign e_q  = rv[2*p] ? signed'(rq[2*p]) : lq;
      assign o_i  = rv[2*p+1] ? signed'(ri[2*p+1]) : ui;
      assign o_q  = rv[2*p+1] ? signed'(rq[2*p+1]) : uq;
      assign fire = act && (hl || rv[2*p]) && (hh || rv[2*p+1]);

      always_comb begin
        if (biphase) begin
          si = {e_i[IN_W-1], e_i} + {o_i[IN_W-1], o_i};
          sq = {e_q[IN_W-1], e_q} + {o_q[IN_W-1], o_q};
        end else begin
          si = {e_i[IN_W-1], e_i} - {o_q[IN_W-1], o_q};
          sq = {o_i[IN_W-1], o_i} + {e_q[IN_W-1], e_q};
        end
      end

      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          hl <= 1'b0;
          hh <= 1'b0;
          li <= '0;
          lq <= '0;
          ui <= '0;
          uq <= '0;
          for (int h = 0; h < 2; h++) begin
            cv[h] <= 1'b0;
            fi[h] <= '0;
            fq[h] <= '0;
          end
        end else begin
          li <= e_i;
          lq <= e_q;
          ui <= o_i;
          uq <= o_q;
          hl <= act && !fire && (hl || rv[2*p]);
          hh <= act && !fire && (hh || rv[2*p+1]);
          if (act) begin
            // merged result on the lower stream only
            cv[0] <= fire;
            cv[1] <= 1'b0;
            fi[0] <= (si[IN_W] != si[IN_W-1]) ? {si[IN_W], {(IN_W-1){~si[IN_W]}}} : si[IN_W-1:0];
            fq[0] <= (sq[IN_W] != sq[IN_W-1]) ? {sq[IN_W], {(IN_W-1){~sq[IN_W]}}} : sq[IN_W-1:0];
          end else begin
            for (int h = 0; h < 2; h++) begin
              cv[h] <= rv[2*p+h];
              fi[h] <= ri[2*p+h];
              fq[h] <= rq[2*p+h];
            end
          end
        end
      end

      for (genvar h = 0; h < 2; h++) begin : g_agc
        localparam int S = 2 * p + h;
        logic                    byp;
        logic                    clipmode;
        logic [4:0]              wl;
        logic signed [INT_W-1:0] gi;
        logic signed [INT_W-1:0] gq;
        logic signed [IN_W-1:0]  ki;
        logic signed [IN_W-1:0]  kq;
        logic signed [INT_W-1:0] mi;
        logic signed [INT_W-1:0] mq;
        logic signed [23:0]      ai;
        logic signed [23:0]      aq;
        logic [47:0]             pwr;
        logic [5:0]              lvl;
        logic signed [8:0]       err;
        logic signed [17:0]      dlt;
        logic signed [GAIN_W+1:0] gn;

        assign byp      = agc_ctl[S][AGC_BYP_BIT];
        assign clipmode = agc_ctl[S][AGC_MODE_BIT];
        assign wl = sca_wlen(agc_ctl[S][AGC_WL_LSB +: 3]);

        function automatic logic signed [INT_W-1:0] gmul(input logic signed [IN_W-1:0] x,
                                                         input logic [3:0] sh);
          logic signed [IN_W+15:0] w;
          w = (IN_W + 16)'(x) <<< sh;
          if (w > (IN_W + 16)'(2 ** (INT_W - 1) - 1)) begin
            gmul = {1'b0, {(INT_W-1){1'b1}}};
          end else if (w < -(IN_W + 16)'(2 ** (INT_W - 1) - 1) - (IN_W + 16)'(1)) begin
            gmul = {1'b1, {(INT_W-1){1'b0}}};
          end else begin
            gmul = w[INT_W-1:0];
          end
        endfunction

        function automatic logic signed [IN_W-1:0] clipw(input logic signed [INT_W-1:0] x,
                                                         input logic [4:0] n);
          logic signed [IN_W-1:0] c;
          c = (x > INT_W'(2 ** (IN_W - 1) - 1)) ? IN_W'(2 ** (IN_W - 1) - 1) :
              (x < -INT_W'(2 ** (IN_W - 1))) ? -IN_W'(2 ** (IN_W - 1)) : x[IN_W-1:0];
          // Low bits below the chosen width are dropped, not rounded
          clipw = c & ~((IN_W'(1) << (5'(IN_W) - n)) - IN_W'(1));
        endfunction

        // gain multiply from the log-domain gain
        assign gi = gmul(fi[h], gain[S][GAIN_W-1 -: 4]);
        assign gq = gmul(fq[h], gain[S][GAIN_W-1 -: 4]);
        // truncate and clip to the width
        assign ki = clipw(gi, wl);
        assign kq = clipw(gq, wl);

        always_comb begin
          mi = gi;
          mq = gq;
          if (clipmode) begin
            mi = gi - INT_W'(ki);
            mq = gq - INT_W'(kq);
          end
          ai  = mi[PWR_LSB +: 24];
          aq  = mq[PWR_LSB +: 24];
          pwr = 48'(ai * ai) + 48'(aq * aq);
          lvl = 6'd0;
          for (int b = 0; b < 48; b++) begin
            if (pwr[b]) begin
              lvl = 6'(b);
            end
          end
          // distance to target; log2 power is doubled amplitude, so the halving is implied
          err = signed'({1'b0, agc_ctl[S][AGC_DES_LSB +: 8]}) - signed'({3'b000, lvl});
          dlt = 18'(err * signed'({1'b0, agc_ctl[S][AGC_K_LSB +: 8]}));
          gn  = signed'({2'b00, gain[S]}) + 14'(dlt >>> K_SHIFT);
        end

        always_ff @(posedge i_clk or negedge i_arst_n) begin
          if (!i_arst_n) begin
            gain[S]                   <= GAIN_RST;
            o_str_valid[S]            <= 1'b0;
            o_str_i[S*OUT_W +: OUT_W] <= '0;
            o_str_q[S*OUT_W +: OUT_W] <= '0;
          end else begin
            o_str_valid[S] <= cv[h];
            if (cv[h]) begin
              if (byp) begin
                // bypass keeps the top sixteen bits
                o_str_i[S*OUT_W +: OUT_W] <= fi[h][IN_W-1 -: OUT_W];
                o_str_q[S*OUT_W +: OUT_W] <= fq[h][IN_W-1 -: OUT_W];
              end else begin
                o_str_i[S*OUT_W +: OUT_W] <= ki[IN_W-1 -: OUT_W];
                o_str_q[S*OUT_W +: OUT_W] <= kq[IN_W-1 -: OUT_W];
                // loop filter update, clamped to the 96 dB span
                gain[S] <= gn < 0 ? GAIN_W'(0) : gn > (2 ** GAIN_W - 1) ? {GAIN_W{1'b1}} : gn[GAIN_W-1:0];
              end
            end
          end
        end
      end
    end
  endgenerate

endmodule

// File: tb/sca_ch_src.sv
// Upstream channel filter model driving per-channel sample strobes
`timescale 1ns/1ps
module sca_ch_src
  import sca_pkg::*;
(
  input  wire logic                i_clk,
  output logic     [NCH*IN_W-1:0]  o_i,
  output logic     [NCH*IN_W-1:0]  o_q,
  output logic     [NCH-1:0]       o_valid
);
  initial begin
    o_i = '0;
    o_q = '0;
    o_valid = '0;
  end
  // Released data lines turn to junk so stale values never pass
  task automatic send(input int c, input logic [IN_W-1:0] si, input logic [IN_W-1:0] sq);
    @(posedge i_clk);
    o_i[c*IN_W+:IN_W] <= si;
    o_q[c*IN_W+:IN_W] <= sq;
    o_valid[c] <= 1'b1;
    @(posedge i_clk);
    o_valid <= '0;
    o_i <= ~o_i;
    o_q <= ~o_q;
  endtask
endmodule

// File: tb/sca_top_assertions.sv
// Port checks of the stream combiner and AGC
`timescale 1ns/1ps
module sca_top_assertions
  import sca_pkg::*;
(
  input wire logic            i_clk,
  input wire logic            i_arst_n,
  input wire logic [NCH-1:0]  i_ch_valid,
  input wire logic [NCH-1:0]  o_str_valid,
  input wire logic            i_s_axi_awvalid,
  input wire logic            o_s_axi_awready,
  input wire logic            i_s_axi_wvalid,
  input wire logic            o_s_axi_wready,
  input wire logic [1:0]      o_s_axi_bresp,
  input wire logic            o_s_axi_bvalid,
  input wire logic            i_s_axi_bready,
  input wire logic            i_s_axi_arvalid,
  input wire logic            o_s_axi_arready,
  input wire logic [31:0]     o_s_axi_rdata,
  input wire logic            o_s_axi_rvalid,
  input wire logic            i_s_axi_rready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------
  // Helper: cycles since the last input sample
  // ----------------------------------------
  logic [3:0] idle;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      idle <= 4'hf;
    end else if (|i_ch_valid) begin
      idle <= 4'h0;
    end else if (idle != 4'hf) begin
      idle <= idle + 4'h1;
    end
  end
  property p_rd_lat; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_b_hold; o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_aw_block; o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken while answering");
  property p_ar_block; o_s_axi_rvalid |-> !o_s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
  property p_b_back; o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid ##1 o_s_axi_awready; endproperty
  a_b_back: assert property (p_b_back) else $error("write ready not restored");
  property p_r_back; o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid ##1 o_s_axi_arready; endproperty
  a_r_back: assert property (p_r_back) else $error("read ready not restored");
  property p_out_cause; |o_str_valid |-> idle < 4'd8; endproperty
  a_out_cause: assert property (p_out_cause) else $error("stream pulse without input");
endmodule
bind sca_top sca_top_assertions u_chk (.*);

// File: tb/sca_top_tb.sv
// Self-checking bench of the stream combiner and AGC
`timescale 1ns/1ps
module sca_top_tb;
  import sca_pkg::*;
  logic                 i_clk, i_arst_n;
  logic [NCH*IN_W-1:0]  i_ch_i, i_ch_q;
  logic [NCH-1:0]       i_ch_valid, o_str_valid;
  logic [NCH*OUT_W-1:0] o_str_i, o_str_q;
  logic [7:0]           i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0]          i_s_axi_wdata, o_s_axi_rdata, rd;
  logic [3:0]           i_s_axi_wstrb;
  logic [1:0]           o_s_axi_bresp, o_s_axi_rresp, rsp;
  logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  int err_count = 0;
  int checked = 0;
  // Leader of each channel per stream code, three bits a channel, channel 5 on top
  logic [17:0] lead [11] = '{18'h2c680, 18'h2c600, 18'h2c000, 18'h28000, 18'h00000, 18'h1b600,
                             18'h24480, 18'h2c480, 18'h2b600, 18'h24000, 18'h2c688};
  localparam logic [21:0] PA = 22'h0a0000, PB = 22'h030000, PC = 22'h010000, PD = 22'h005000;
  sca_top dut (.*);
  sca_ch_src src (.i_clk(i_clk), .o_i(i_ch_i), .o_q(i_ch_q), .o_valid(i_ch_valid));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s);
    logic aw, w;
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= dt;
    i_s_axi_wstrb <= s;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    i_s_axi_bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (!aw && o_s_axi_awready) begin
        aw = 1'b1;
        i_s_axi_awvalid <= 1'b0;
      end
      if (!w && o_s_axi_wready) begin
        w = 1'b1;
        i_s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while (o_s_axi_bvalid !== 1'b1);
    rsp = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do @(posedge i_clk); while (o_s_axi_arready !== 1'b1);
    i_s_axi_arvalid <= 1'b0;
    do @(posedge i_clk); while (o_s_axi_rvalid !== 1'b1);
    rd = o_s_axi_rdata;
    rsp = o_s_axi_rresp;
    i_s_axi_rready <= 1'b0;
  endtask
  // Merged pair result, saturated to 22 bits, top 16 bits kept
  function automatic logic [15:0] t16(input logic signed [21:0] x, input logic signed [21:0] y, input bit sub);
    logic signed [22:0] v;
    v = sub ? x - y : x + y;
    if (v > 23'sh1fffff) v = 23'sh1fffff;
    else if (v < -23'sh200000) v = -23'sh200000;
    return v[21:6];
  endfunction
  task automatic expect_out(input int s, input logic [15:0] ei, input logic [15:0] eq);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_str_valid === '0 && n < 10);
    check(32'(o_str_valid), 32'h1 << s);
    check(32'(o_str_i[s*OUT_W+:OUT_W]), 32'(ei));
    check(32'(o_str_q[s*OUT_W+:OUT_W]), 32'(eq));
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [IN_W-1:0] v;
    i_arst_n = 1'b0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_wstrb} = '0;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = '0;
    repeat (10) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd_reg(ADDR_OUT_CTRL);
    check(rd, 32'h0000_000f);
    rd_reg(ADDR_AGC_CTRL0 + 8'h14);
    check(rd, 32'h0010_2001);
    rd_reg(8'h80);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(ADDR_AGC_GAIN0, 32'h1, 4'hf);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(ADDR_OUT_CTRL, 32'hffff_ffff, 4'he);
    rd_reg(ADDR_OUT_CTRL);
    check(rd, 32'h0000_000f);
    // Stream codes 0 to 10, every channel, with AGCs bypassed
    for (int sc = 0; sc < 11; sc++) begin
      wr(ADDR_OUT_CTRL, 32'(sc), 4'h1);
      for (int ch = 0; ch < 6; ch++) begin
        v = 22'(ch * 4096 + sc * 64 + 5);
        src.send(ch, v, ~v);
        expect_out(int'(lead[sc][ch*3+:3]), v[21:6], ~v[21:6]);
      end
    end
    // Every complex code on the pair of channels 2 and 3
    for (int cc = 0; cc < 8; cc++) begin
      wr(ADDR_OUT_CTRL, 32'(cc * 16 + 15), 4'h1);
      src.send(2, PA, PB);
      if (cc == 2 || cc == 3 || cc >= 6) begin
        src.send(3, PC, PD);
        expect_out(2, t16(PA, cc < 4 ? PD : PC, cc < 4), t16(PB, cc < 4 ? PC : PD, 0));
      end else begin
        expect_out(2, PA[21:6], PB[21:6]);
        src.send(3, PC, PD);
        expect_out(3, PC[21:6], PD[21:6]);
      end
    end
    src.send(0, 22'h1ff000, 22'h0);
    src.send(1, 22'h1ff000, 22'h0);
    expect_out(0, 16'h7fff, 16'h0000);
    // Live AGC with four-bit words: low bits dropped, gain moves
    wr(ADDR_OUT_CTRL, 32'hf, 4'h1);
    wr(ADDR_AGC_CTRL0, 32'h0010_2000, 4'hf);
    src.send(0, 22'h0abcde, 22'h3f0000);
    expect_out(0, 16'h2000, 16'hf000);
    rd_reg(ADDR_AGC_GAIN0);
    check(rd, 32'h2);
    // Clip-level mode, 16-bit words
    wr(ADDR_AGC_CTRL0, 32'h0010_201e, 4'hf);
    src.send(0, 22'h0abcde, 22'h3f0000);
    expect_out(0, 16'h2af3, 16'hfc00);
    rd_reg(ADDR_AGC_GAIN0);
    check(rd, 32'h22);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    report_and_stop();
  end
endmodule
